// >>> logic/sfc_core.sv
// Serial flash command core: frame decoder, reads, status and self-timed cycles
`timescale 1ns/100ps

// Functional notes
// - Set-latch opcode in a complete frame sets the write enable latch.
// - Clear-latch opcode in a complete frame clears the write enable latch.
// - Latch clears at reset and when any status write, program or erase completes.
// - Status read works anytime, even busy, repeating bits 7..0 while clocked.
// - Status write is opcode plus one byte, accepted only with latch set.
// - Status write keeps bits 7,4,3,2; bits 6 and 5 read zero.
// - Status write runs only if select rises right after its data byte.
// - Valid status write starts a timed cycle, busy high, latch cleared after.
// - Hardware protected mode blocks status writes entirely.
// - Normal read takes 24-bit address, streams incrementing data on falling edges.
// - Normal read while busy is rejected; running cycle continues.
// - Fast read takes address plus dummy byte, then streams data.
// - Dual read sends bits 7,5,3,1 on line one and 6,4,2,0 on zero.
// - Program data past page end wraps to that page's start.
// - Only last 256 bytes kept; unaddressed page bytes stay untouched.
// - Program runs only on byte-aligned end, timed cycle, busy set, latch cleared.
// - Program into a block-protected page is not executed.
// - Sector erase uses any address in sector, starts on end after address.
// - Erase of a block-protected sector is not executed.
// - Hardware protected mode holds when protect bit set and write-protect low.
// - Write-type commands need select to rise after whole bytes only.
// - Everything moves MSB first, inputs sampled on rising serial clock.
module sfc_core #(
  parameter int MEM_AW = 17,
  parameter int STATUS_WRITE_CYCLES = sfc_pkg::STATUS_WRITE_CYC,
  parameter int PAGE_PROGRAM_CYCLES = sfc_pkg::PAGE_PROGRAM_CYC,
  parameter int SECTOR_ERASE_CYCLES = sfc_pkg::SECTOR_ERASE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire sfc_pkg::sfc_pin_in_t pins_in,
  output sfc_pkg::sfc_pin_out_t pins_out,
  output logic [7:0] status,
  output logic hardware_protected_mode
);
  import sfc_pkg::*;

  // ==========================================================================
  // Elaboration checks: address width in range, program and erase walks fit inside their timed cycles
  if (MEM_AW < 16 || MEM_AW > 24) begin : g_bad_aw
    $error("MEM_AW must lie between 16 and 24");
  end
  if (PAGE_PROGRAM_CYCLES < PAGE_BYTES || SECTOR_ERASE_CYCLES < SECTOR_BYTES ||
      STATUS_WRITE_CYCLES < 1) begin : g_bad_cyc
    $error("Cycle counts too short for the array walk");
  end

  // ==========================================================================
  // Block protect decode, shared by program and erase
  function automatic logic is_prot(input logic [2:0] bp, input logic [23:0] a);
    logic [3:0] sec;
    sec = a[15:SECTOR_LSB];
    if (bp[2]) begin
      is_prot = 1'b1;
    end else if (bp[1:0] == 2'h1) begin
      is_prot = sec < PROT_LIM_1;
    end else if (bp[1:0] == 2'h2) begin
      is_prot = sec < PROT_LIM_2;
    end else if (bp[1:0] == 2'h3) begin
      is_prot = sec < PROT_LIM_3;
    end else begin
      is_prot = 1'b0;
    end
  endfunction

  // ==========================================================================
  // Storage
  logic [7:0] mem [0:(1 << MEM_AW) - 1];
  logic [7:0] pbuf [0:PAGE_BYTES - 1];
  logic [PAGE_BYTES-1:0] pmask_q;

  sfc_pin_in_t pin_s1_q, pin_s2_q;
  logic sclk_d_q, cs_d_q;
  logic [6:0] sh_q;
  logic [2:0] bit_q, idx_q;
  logic [7:0] op_q, sr_new_q;
  logic [23:0] addr_q, tgt_q;
  logic prot_q, wel_q;
  logic [2:0] bp_q;
  logic [7:0] out_q;
  logic tx_on_q, tx_dual_q, tx_sr_q;
  logic [2:0] tx_cnt_q;
  sfc_pin_out_t pout_q;
  logic [7:0] status_q;
  logic hw_lock_q;
  sfc_cycle_t cyc_q;
  logic [31:0] cnt_q;
  logic [11:0] walk_q;

  // ==========================================================================
  // Pin synchronisers; only the second stage is ever decoded
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_s1_q <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0, wp_n: 1'b1};
      pin_s2_q <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0, wp_n: 1'b1};
      sclk_d_q <= 1'b0;
      cs_d_q <= 1'b1;
    end else if (ce) begin
      pin_s1_q <= pins_in;
      pin_s2_q <= pin_s1_q;
      sclk_d_q <= pin_s2_q.sclk;
      cs_d_q <= pin_s2_q.cs_n;
    end
  end

  // Edge and byte decode
  wire sel = ~pin_s2_q.cs_n;
  wire sclk_rise = sel & pin_s2_q.sclk & ~sclk_d_q;
  wire sclk_fall = sel & ~pin_s2_q.sclk & sclk_d_q;
  wire cs_rise = pin_s2_q.cs_n & ~cs_d_q;
  wire [7:0] byte_in = {sh_q, pin_s2_q.si};
  wire byte_done = sclk_rise & (bit_q == 3'h7);
  wire [2:0] idx_nx = (idx_q == IDX_MAX) ? IDX_MAX : idx_q + 3'h1;
  wire [23:0] addr_nx = {addr_q[15:0], byte_in};
  wire busy = (cyc_q != CYC_IDLE);
  // protected mode from protect bit and pin
  wire hw_lock = prot_q & ~pin_s2_q.wp_n;
  // bits 6 and 5 fixed at zero
  wire [7:0] status_now = {prot_q, 2'b00, bp_q, wel_q, busy};

  // Frame end decode; only whole bytes count
  wire on_bound = cs_rise & (bit_q == 3'h0);
  wire end_set = on_bound & (op_q == OP_SET_LATCH) & (idx_q == LEN_CMD) & ~busy;
  wire end_clr = on_bound & (op_q == OP_CLR_LATCH) & (idx_q == LEN_CMD) & ~busy;
  // status write needs latch, exact length, no hardware lock
  wire start_wsr = on_bound & (op_q == OP_SR_WR) & (idx_q == LEN_SR_WR) &
                   wel_q & ~hw_lock & ~busy;
  // program needs a data byte and an unlocked page
  wire start_prog = on_bound & (op_q == OP_PROG) & (idx_q >= LEN_PROG_MIN) &
                  wel_q & ~busy & ~is_prot(bp_q, addr_q);
  // erase ends right after the address, sector unlocked
  wire start_erase = on_bound & (op_q == OP_SECT) & (idx_q == LEN_ERASE) &
                  wel_q & ~busy & ~is_prot(bp_q, addr_q);
  wire cyc_done = busy & (cnt_q == 32'h0000_0000);

  // Read launch decode; array reads refused while busy
  wire sr_load = byte_done & (idx_q == IDX_OPCODE) & (byte_in == OP_SR_RD);
  wire rd_norm = byte_done & ~busy & (idx_q == IDX_ADDR_LAST) & (op_q == OP_READ);
  wire rd_fast = byte_done & ~busy & (idx_q == IDX_DUMMY) &
                 ((op_q == OP_FAST) | (op_q == OP_DUAL));
  wire prog_data = byte_done & ~busy & (op_q == OP_PROG) & (idx_q >= IDX_DUMMY);
  wire [23:0] rd_a = rd_norm ? addr_nx : addr_q;
  wire [7:0] mem_rd = mem[rd_a[MEM_AW-1:0]];
  wire [2:0] tx_step = tx_dual_q ? 3'h2 : 3'h1;
  wire [2:0] tx_cnt_nx = tx_cnt_q + tx_step;

  // ==========================================================================
  // Serial input shifter and frame counters; bit and byte counters cleared while deselected
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sh_q <= 7'h00;
      bit_q <= 3'h0;
      idx_q <= 3'h0;
      op_q <= 8'h00;
      sr_new_q <= 8'h00;
    end else if (ce) begin
      if (pin_s2_q.cs_n) begin
        bit_q <= 3'h0;
        idx_q <= 3'h0;
      end else if (sclk_rise) begin
        sh_q <= byte_in[6:0];
        bit_q <= bit_q + 3'h1;
        if (bit_q == 3'h7) begin
          idx_q <= idx_nx;
        end
      end
      if (byte_done && idx_q == IDX_OPCODE) begin
        op_q <= byte_in;
      end
      if (byte_done && idx_q == LEN_CMD && op_q == OP_SR_WR) begin
        sr_new_q <= byte_in;
      end
    end
  end

  // ==========================================================================
  // Address register and output shifter; outputs change on falling clock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_q <= 24'h00_0000;
      out_q <= 8'h00;
      tx_on_q <= 1'b0;
      tx_dual_q <= 1'b0;
      tx_sr_q <= 1'b0;
      tx_cnt_q <= 3'h0;
      pout_q <= '0;
    end else if (ce) begin
      if (pin_s2_q.cs_n) begin
        tx_on_q <= 1'b0;
        pout_q <= '0;
      end else if (sr_load) begin
        // status streams from the opcode on, busy or not
        out_q <= status_now;
        tx_on_q <= 1'b1;
        tx_sr_q <= 1'b1;
        tx_dual_q <= 1'b0;
        tx_cnt_q <= 3'h0;
      end else if (rd_norm || rd_fast) begin
        // first byte fetched, address moves past it
        out_q <= mem_rd;
        addr_q <= rd_a + 24'h00_0001;
        tx_on_q <= 1'b1;
        tx_sr_q <= 1'b0;
        tx_dual_q <= (op_q == OP_DUAL);
        tx_cnt_q <= 3'h0;
      end else if (byte_done && idx_q != IDX_OPCODE && idx_q <= IDX_ADDR_LAST) begin
        addr_q <= addr_nx;
      end else if (prog_data) begin
        // low byte wraps inside the page
        addr_q[7:0] <= addr_q[7:0] + 8'h01;
      end else if (sclk_fall && tx_on_q) begin
        // dual: line one carries odd bits, line zero even bits; single: all bits on line one
        pout_q.dual_line_one <= out_q[7];
        pout_q.dual_line_one_oe <= 1'b1;
        pout_q.dual_line_zero <= out_q[6];
        pout_q.dual_line_zero_oe <= tx_dual_q;
        tx_cnt_q <= tx_cnt_nx;
        if (tx_cnt_nx == 3'h0) begin
          out_q <= tx_sr_q ? status_now : mem_rd;
          if (!tx_sr_q) begin
            addr_q <= addr_q + 24'h00_0001;
          end
        end else begin
          out_q <= tx_dual_q ? {out_q[5:0], 2'b00} : {out_q[6:0], 1'b0};
        end
      end
    end
  end

  // ==========================================================================
  // Page buffer; a busy walk reads it, so new data waits for idle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pmask_q <= '0;
    end else if (ce) begin
      if (cs_d_q && !pin_s2_q.cs_n && !busy) begin
        pmask_q <= '0;
      end else if (prog_data) begin
        // later bytes overwrite earlier ones at the same offset
        pmask_q[addr_q[7:0]] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce && prog_data) begin
      pbuf[addr_q[7:0]] <= byte_in;
    end
  end

  // ==========================================================================
  // Status bits; latch set wins over nothing, completion clears it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      // latch and protect bits clear at power-up
      wel_q <= 1'b0;
      prot_q <= 1'b0;
      bp_q <= BP_RESET;
    end else if (ce) begin
      if (end_set) begin
        wel_q <= 1'b1;
      end else if (end_clr || cyc_done) begin
        // clear latch on command or completion
        wel_q <= 1'b0;
      end
      if (cyc_done && cyc_q == CYC_SR_WR) begin
        // only protect and block bits take the new byte
        prot_q <= sr_new_q[SR_PROT];
        bp_q <= sr_new_q[SR_BP_HI:SR_BP_LO];
      end
    end
  end

  // ==========================================================================
  // Self-timed cycle sequencer
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cyc_q <= CYC_IDLE;
      cnt_q <= 32'h0000_0000;
      walk_q <= 12'h000;
      tgt_q <= 24'h00_0000;
    end else if (ce) begin
      case (cyc_q)
        CYC_IDLE: begin
          walk_q <= 12'h000;
          tgt_q <= addr_q;
          if (start_wsr) begin
            cyc_q <= CYC_SR_WR;
            cnt_q <= 32'(STATUS_WRITE_CYCLES - 1);
          end else if (start_prog) begin
            cyc_q <= CYC_PROG;
            cnt_q <= 32'(PAGE_PROGRAM_CYCLES - 1);
          end else if (start_erase) begin
            cyc_q <= CYC_ERASE;
            cnt_q <= 32'(SECTOR_ERASE_CYCLES - 1);
          end
        end
        default: begin
          cnt_q <= cnt_q - 32'h0000_0001;
          walk_q <= walk_q + 12'h001;
          if (cyc_done) begin
            cyc_q <= CYC_IDLE;
          end
        end
      endcase
    end
  end

  // Array walk: one byte per cycle during program or erase
  wire prog_we = (cyc_q == CYC_PROG) & (walk_q < 12'(PAGE_BYTES)) &
                 pmask_q[walk_q[7:0]];
  wire erase_we = (cyc_q == CYC_ERASE);
  wire [23:0] prog_a = {tgt_q[23:8], walk_q[7:0]};
  wire [23:0] erase_a = {tgt_q[23:SECTOR_LSB], walk_q};

  always_ff @(posedge clk) begin
    if (ce && prog_we) begin
      mem[prog_a[MEM_AW-1:0]] <= pbuf[walk_q[7:0]];
    end else if (ce && erase_we) begin
      mem[erase_a[MEM_AW-1:0]] <= ERASED_BYTE;
    end
  end

  // ==========================================================================
  // Registered status outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_q <= 8'h00;
      hw_lock_q <= 1'b0;
    end else if (ce) begin
      status_q <= status_now;
      hw_lock_q <= hw_lock;
    end
  end

  assign pins_out = pout_q;
  assign status = status_q;
  assign hardware_protected_mode = hw_lock_q;

endmodule

// >>> logic/sfc_pkg.sv
// Shared constants and types of the serial flash command core
package sfc_pkg;

  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_SR_RD = 8'h05;
  localparam logic [7:0] OP_SR_WR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DUAL = 8'h3B;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SECT = 8'h20;

  // ==========================================================================
  // Status word layout and reset value
  localparam int SR_BUSY = 0;
  localparam int SR_LATCH = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_BP_HI = 4;
  localparam int SR_PROT = 7;
  localparam logic [2:0] BP_RESET = 3'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ==========================================================================
  // Frame layout in byte counts
  localparam logic [2:0] IDX_OPCODE = 3'h0;
  localparam logic [2:0] IDX_ADDR_LAST = 3'h3;
  localparam logic [2:0] IDX_DUMMY = 3'h4;
  localparam logic [2:0] IDX_MAX = 3'h7;
  localparam logic [2:0] LEN_CMD = 3'h1;
  localparam logic [2:0] LEN_SR_WR = 3'h2;
  localparam logic [2:0] LEN_ERASE = 3'h4;
  localparam logic [2:0] LEN_PROG_MIN = 3'h5;

  // ==========================================================================
  // Array geometry and protection limits (sector index below limit is locked)
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_BYTES = 4096;
  localparam int SECTOR_LSB = 12;
  localparam logic [3:0] PROT_LIM_1 = 4'hE;
  localparam logic [3:0] PROT_LIM_2 = 4'hC;
  localparam logic [3:0] PROT_LIM_3 = 4'h8;

  // ==========================================================================
  // Self-timed cycle durations
  localparam int CLK_MHZ = 50;
  localparam int STATUS_WRITE_TIME_US = 5000;
  localparam int PAGE_PROGRAM_TIME_US = 600;
  localparam int SECTOR_ERASE_TIME_US = 50000;
  localparam int STATUS_WRITE_CYC = STATUS_WRITE_TIME_US * CLK_MHZ;
  localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_TIME_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;

  // ==========================================================================
  // Types
  typedef enum logic [3:0] {
    CYC_IDLE = 4'b0001,
    CYC_SR_WR = 4'b0010,
    CYC_PROG = 4'b0100,
    CYC_ERASE = 4'b1000
  } sfc_cycle_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic si;
    logic wp_n;
  } sfc_pin_in_t;

  typedef struct packed {
    logic dual_line_one;
    logic dual_line_one_oe;
    logic dual_line_zero;
    logic dual_line_zero_oe;
  } sfc_pin_out_t;

endpackage

// >>> tb/sfc_core_props.sv
// Port-level assertion checker of the serial flash command core
`timescale 1ns/100ps
module sfc_core_props #(
  parameter int STATUS_WRITE_CYCLES = 20,
  parameter int SECTOR_ERASE_CYCLES = 4200
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire sfc_pkg::sfc_pin_in_t pins_in,
  input wire sfc_pkg::sfc_pin_out_t pins_out,
  input wire logic [7:0] status,
  input wire logic hardware_protected_mode
);
  import sfc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn || !ce);
  // ==========================================================================
  // Busy length counter; a frozen clock enable freezes it as well
  int busy_cnt_q;
  int busy_cnt_d;
  assign busy_cnt_d = status[SR_BUSY] ? busy_cnt_q + 1 : 0;
  always_ff @(posedge clk) begin
    if (!rstn) busy_cnt_q <= 0;
    else if (ce) busy_cnt_q <= busy_cnt_d;
  end
  // ==========================================================================
  // Named sequences: pins settled long enough to pass the synchronisers
  sequence prot_pin_s;
    (status[SR_PROT] && !pins_in.wp_n) [*6];
  endsequence
  sequence free_pin_s;
    pins_in.wp_n [*6];
  endsequence
  sequence deselect_s;
    pins_in.cs_n [*6];
  endsequence
  // ==========================================================================
  // Assertions
  rsvd_zero_a: assert property (status[6:5] == 2'b00)
    else $error("reserved status bits not zero");
  busy_cap_a: assert property (busy_cnt_q <= SECTOR_ERASE_CYCLES + 16)
    else $error("busy lasts too long");
  busy_floor_a: assert property ($fell(status[SR_BUSY]) |->
    busy_cnt_q >= STATUS_WRITE_CYCLES - 2) else $error("busy too short");
  busy_needs_latch_a: assert property ($rose(status[SR_BUSY]) |->
    status[SR_LATCH] && pins_in.cs_n) else $error("cycle without latch");
  latch_idle_a: assert property ($rose(status[SR_LATCH]) |->
    pins_in.cs_n && !status[SR_BUSY]) else $error("latch set at wrong time");
  done_clears_a: assert property ($fell(status[SR_BUSY]) |-> !status[SR_LATCH])
    else $error("latch left set after cycle");
  dual_pair_a: assert property (pins_out.dual_line_zero_oe |->
    pins_out.dual_line_one_oe) else $error("line zero driven alone");
  deselect_quiet_a: assert property (deselect_s |-> !pins_out.dual_line_one_oe
    && !pins_out.dual_line_zero_oe) else $error("lines driven while deselected");
  prot_on_a: assert property (prot_pin_s |-> hardware_protected_mode)
    else $error("protected mode missing");
  prot_off_a: assert property (free_pin_s |-> !hardware_protected_mode)
    else $error("protected mode with pin high");
  prot_freeze_a: assert property (hardware_protected_mode [*2] |->
    $stable(status[7:2])) else $error("status changed in protected mode");
endmodule

bind sfc_core sfc_core_props #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES),
  .SECTOR_ERASE_CYCLES(SECTOR_ERASE_CYCLES)) props (.clk(clk), .rstn(rstn), .ce(ce),
  .pins_in(pins_in), .pins_out(pins_out), .status(status),
  .hardware_protected_mode(hardware_protected_mode));

// >>> tb/sfc_host.sv
// Host controller model driving the serial link of the flash core
`timescale 1ns/100ps
module sfc_host (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic line_one,
  input wire logic line_zero
);
  // ==========================================================================
  // Idle: deselected, serial clock parked low between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end
  // Steps just past the edge so pin changes never race it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic start();
    tick(1);
    cs_n = 1'b0;
    tick(4);
  endtask
  // select rises after the last bit sent, on or off a byte boundary; a released data line shows the inverse
  task automatic stop();
    tick(4);
    cs_n = 1'b1;
    si = ~si;
    tick(10);
  endtask
  // MSB first; answer taken late in the high phase, once settled
  task automatic xbits(input logic [7:0] tx, input int n, input bit dual,
      output logic [7:0] rx);
    rx = 8'h00;
    for (int k = 0; k < n; k++) begin
      si = dual ? ~si : tx[7 - k];
      tick(4);
      sclk = 1'b1;
      tick(4);
      rx = dual ? {rx[5:0], line_one, line_zero} : {rx[6:0], line_one};
      sclk = 1'b0;
    end
  endtask
endmodule

// >>> tb/tb_sfc_core.sv
// Self-checking testbench of the serial flash command core
`timescale 1ns/100ps
module tb_sfc_core;
  import sfc_pkg::*;
  logic clk, rstn, ce, wp_n, cs_n, sclk, si, oe_seen, prot_mode;
  sfc_pin_in_t pins_in;
  sfc_pin_out_t pins_out;
  logic [7:0] status;
  int mismatches, cmp_count;
  // ==========================================================================
  // Clock, shared line and instances
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Line zero is shared; the core owns it while its enable is high
  assign pins_in = '{cs_n: cs_n, sclk: sclk, wp_n: wp_n,
    si: pins_out.dual_line_zero_oe ? pins_out.dual_line_zero : si};
  sfc_core #(.STATUS_WRITE_CYCLES(20), .PAGE_PROGRAM_CYCLES(300),
    .SECTOR_ERASE_CYCLES(4200)) uut (.clk(clk), .rstn(rstn), .ce(ce), .pins_in(pins_in),
    .pins_out(pins_out), .status(status), .hardware_protected_mode(prot_mode));
  // A released output line shows the inverse of its last value, so early samples fail
  wire one_seen = pins_out.dual_line_one_oe ? pins_out.dual_line_one :
    ~pins_out.dual_line_one;
  wire zero_seen = pins_out.dual_line_zero_oe ? pins_out.dual_line_zero :
    ~pins_out.dual_line_zero;
  sfc_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si),
    .line_one(one_seen), .line_zero(zero_seen));
  // Records any drive of the output lines
  always @(posedge clk) if (pins_out.dual_line_one_oe) oe_seen <= 1'b1;
  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_q(input logic [7:0] d[$], input logic [7:0] e[$], input string what);
    foreach (e[i]) check(d[i], e[i], what);
  endtask
  task automatic send(input logic [7:0] q[$], input int extra);
    logic [7:0] r;
    host.start();
    foreach (q[i]) host.xbits(q[i], 8, 1'b0, r);
    if (extra > 0) host.xbits(8'hFF, extra, 1'b0, r);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n,
      output logic [7:0] d[$]);
    logic [7:0] r;
    d = {};
    host.start();
    host.xbits(op, 8, 1'b0, r);
    if (op != OP_SR_RD) for (int i = 2; i >= 0; i--) host.xbits(a[8*i+:8], 8, 1'b0, r);
    if (op == OP_FAST || op == OP_DUAL) host.xbits(8'h00, 8, 1'b0, r);
    repeat (n) begin
      host.xbits(8'h00, (op == OP_DUAL) ? 4 : 8, op == OP_DUAL, r);
      d.push_back(r);
    end
    host.stop();
  endtask
  // Polls busy with a bounded wait
  task automatic wait_idle();
    int n;
    n = 0;
    while (status[SR_BUSY] !== 1'b0 && n < 10000) begin
      @(posedge clk);
      n++;
    end
    #1;
    check({7'h00, n < 10000}, 8'h01, "busy ends");
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_latch();
    check(status, 8'h00, "reset status");
    send('{OP_SET_LATCH}, 0);
    check(status, 8'h02, "latch set");
    send('{OP_CLR_LATCH}, 0);
    check(status, 8'h00, "latch clear");
    send('{OP_SET_LATCH}, 3);
    check(status, 8'h00, "ragged set");
    send('{OP_SR_WR, 8'h1C}, 0);
    check(status, 8'h00, "write without latch");
    $display("test latch done");
  endtask
  task automatic t_status();
    send('{OP_SET_LATCH}, 0);
    send('{OP_SR_WR, 8'h1C}, 1);
    check(status, 8'h02, "ragged write");
    send('{OP_SR_WR, 8'hFF}, 0);
    check(status, 8'h03, "write busy");
    wait_idle();
    check(status, 8'h9C, "written status");
    wp_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check({7'h00, prot_mode}, 8'h01, "protected mode");
    send('{OP_SET_LATCH}, 0);
    send('{OP_SR_WR, 8'h00}, 0);
    check(status, 8'h9E, "write in protected mode");
    wp_n = 1'b1;
    send('{OP_SR_WR, 8'h04}, 0);
    wait_idle();
    check(status, 8'h04, "block protect set");
    $display("test status done");
  endtask
  task automatic t_protect();
    send('{OP_SET_LATCH}, 0);
    send('{OP_SECT, 8'h00, 8'h10, 8'h00}, 0);
    check(status, 8'h06, "locked erase");
    send('{OP_PROG, 8'h00, 8'h10, 8'h00, 8'h55}, 0);
    check(status, 8'h06, "locked program");
    send('{OP_SR_WR, 8'h00}, 0);
    wait_idle();
    check(status, 8'h00, "protect cleared");
    $display("test protect done");
  endtask
  task automatic t_array();
    logic [7:0] d[$];
    send('{OP_SET_LATCH}, 0);
    send('{OP_SECT, 8'h00, 8'h1F, 8'h44}, 0);
    rd(OP_SR_RD, 24'h00_0000, 2, d);
    check_q(d, '{8'h03, 8'h03}, "status stream");
    oe_seen = 1'b0;
    rd(OP_READ, 24'h00_1000, 1, d);
    check({7'h00, oe_seen}, 8'h00, "read while busy");
    wait_idle();
    check(status, 8'h00, "erase done");
    send('{OP_SET_LATCH}, 0);
    send('{OP_PROG, 8'h00, 8'h10, 8'hFE, 8'hA1, 8'hA2, 8'hA3}, 0);
    wait_idle();
    check(status, 8'h00, "program done");
    rd(OP_READ, 24'h00_10FE, 3, d);
    check_q(d, '{8'hA1, 8'hA2, 8'hFF}, "read");
    rd(OP_READ, 24'h00_1000, 2, d);
    check_q(d, '{8'hA3, 8'hFF}, "page wrap");
    rd(OP_FAST, 24'h00_10FE, 2, d);
    check_q(d, '{8'hA1, 8'hA2}, "fast read");
    rd(OP_DUAL, 24'h00_10FF, 2, d);
    check_q(d, '{8'hA2, 8'hFF}, "dual read");
    $display("test array done");
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    ce = 1'b1;
    wp_n = 1'b1;
    rstn = 1'b0;
    oe_seen = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_latch();
    t_status();
    t_protect();
    t_array();
    conclude();
  end
  // The run needs well under a millisecond; this cuts a hang short
  initial begin
    #1000000;
    mismatches++;
    $display("ERROR at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
